// ==== src/wdt_pkg.sv ====
// Package: register map, field layout and timing constants of the watchdog
package wdt_pkg;

    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;

    // Register offsets
    localparam logic [3:0] CTRL_OFFS   = 4'h0;
    localparam logic [3:0] STATUS_OFFS = 4'h4;
    localparam logic [3:0] COUNT_OFFS  = 4'h8;

    // Control field positions
    localparam int CTRL_SEL_LSB  = 0;
    localparam int CTRL_IE_BIT   = 2;
    localparam int CTRL_RSTE_BIT = 3;
    localparam int CTRL_RWT_BIT  = 4;
    // Status field positions
    localparam int STAT_TOF_BIT  = 0;
    localparam int STAT_PEND_BIT = 1;

    // Reset values
    localparam logic [1:0] SEL_RST  = 2'h0;
    localparam logic       IE_RST   = 1'b0;
    localparam logic       RSTE_RST = 1'b0;

    // Interval exponents for select codes 00..11
    localparam int EXP_SEL0 = 15;
    localparam int EXP_SEL1 = 18;
    localparam int EXP_SEL2 = 21;
    localparam int EXP_SEL3 = 24;

    // Reset delay after timeout, in system clocks
    localparam int RST_DELAY_CYC = 512;
    localparam int CNT_W         = 25;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } bus_req_s;

    typedef struct packed {
        logic [1:0] interval_select;
        logic       irq_enable;
        logic       reset_enable;
    } ctrl_s;

endpackage

// ==== src/wdt_delay.sv ====
// Counter for the fixed reset delay that follows a watchdog timeout
`timescale 1ns/10ps
module wdt_delay #(
    parameter int DELAY = wdt_pkg::RST_DELAY_CYC
) (
    input  wire logic i_core_clk,
    input  wire logic i_arst_n,
    input  wire logic i_start,
    input  wire logic i_cancel,
    output logic      o_pending,
    output logic      o_expire
);
    localparam int W = $clog2(DELAY + 1);
    localparam logic [W-1:0] LAST = W'(DELAY - 1);

    logic [W-1:0] cnt_reg;
    logic         pend_reg;

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pend_reg <= 1'b0;
            cnt_reg  <= '0;
        end else if (i_cancel) begin
            pend_reg <= 1'b0;
            cnt_reg  <= '0;
        end else if (i_start) begin
            pend_reg <= 1'b1;
            cnt_reg  <= '0;
        end else if (pend_reg) begin
            if (cnt_reg == LAST) begin
                pend_reg <= 1'b0;
            end
            cnt_reg <= cnt_reg + 1'b1;
        end
    end

    assign o_pending = pend_reg;
    assign o_expire  = pend_reg && (cnt_reg == LAST) && !i_cancel;
endmodule

// ==== src/wdt_core.sv ====
// Watchdog timer: interval counter, timeout flag, interrupt and reset delay
//
// Notes on behaviour
// - Free-running counter, software restarts to zero
// - Interval between 2^15 and 2^24 clocks
// - Interrupt on timeout only when enabled
// - System reset 512 clocks after timeout
// - Select 00/01/10/11 gives 2^15/18/21/24
`timescale 1ns/10ps
module wdt_core (
    input  wire logic                        i_core_clk,
    input  wire logic                        i_arst_n,
    input  wire logic [wdt_pkg::ADDR_W-1:0]  i_addr,
    input  wire logic [wdt_pkg::DATA_W-1:0]  i_wdata,
    input  wire logic                        i_wr,
    input  wire logic                        i_rd,
    output logic      [wdt_pkg::DATA_W-1:0]  o_rdata,
    output logic                             o_irq,
    output logic                             o_sys_rst
);
    localparam int CW = wdt_pkg::CNT_W;

    wdt_pkg::bus_req_s req;
    wdt_pkg::ctrl_s    ctrl_reg;
    logic [CW-1:0]     count_reg;
    logic              tof_reg;
    logic              irq_reg;
    logic              rst_reg;
    logic [wdt_pkg::DATA_W-1:0] rdata_reg;
    logic              restart;
    logic              tof_clr;
    logic              timeout;
    logic              pending;
    logic              expire;
    logic [9:0]        since_reg;

    assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

    // Terminal count for a select code
    function automatic logic [CW-1:0] interval_last(input logic [1:0] sel);
        unique case (sel)
            2'h0: interval_last = CW'((1 << wdt_pkg::EXP_SEL0) - 1);
            2'h1: interval_last = CW'((1 << wdt_pkg::EXP_SEL1) - 1);
            2'h2: interval_last = CW'((1 << wdt_pkg::EXP_SEL2) - 1);
            2'h3: interval_last = CW'((1 << wdt_pkg::EXP_SEL3) - 1);
        endcase
    endfunction

    // Write strobe aimed at one register offset
    function automatic logic wr_hit(input wdt_pkg::bus_req_s r,
                                    input logic [wdt_pkg::ADDR_W-1:0] offs);
        wr_hit = r.wr && r.addr == offs;
    endfunction

    assign restart = wr_hit(req, wdt_pkg::CTRL_OFFS)
                     && req.wdata[wdt_pkg::CTRL_RWT_BIT];
    assign tof_clr = wr_hit(req, wdt_pkg::STATUS_OFFS)
                     && req.wdata[wdt_pkg::STAT_TOF_BIT];
    // Compare with >= so that a shorter select written mid-interval fires
    // at once instead of letting the counter run on to its own wrap
    assign timeout = !restart
                     && count_reg >= interval_last(ctrl_reg.interval_select);

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ctrl_reg.interval_select <= wdt_pkg::SEL_RST;
            ctrl_reg.irq_enable      <= wdt_pkg::IE_RST;
            ctrl_reg.reset_enable    <= wdt_pkg::RSTE_RST;
        end else if (wr_hit(req, wdt_pkg::CTRL_OFFS)) begin
            ctrl_reg.interval_select <=
                req.wdata[wdt_pkg::CTRL_SEL_LSB +: 2];
            ctrl_reg.irq_enable   <= req.wdata[wdt_pkg::CTRL_IE_BIT];
            ctrl_reg.reset_enable <= req.wdata[wdt_pkg::CTRL_RSTE_BIT];
        end
    end

    // Counter wraps to zero at the interval end, so it keeps running
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            count_reg <= '0;
        end else if (restart || timeout) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_reg + 1'b1;
        end
    end

    // Set wins over a simultaneous software clear
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            tof_reg <= 1'b0;
        end else if (timeout) begin
            tof_reg <= 1'b1;
        end else if (tof_clr) begin
            tof_reg <= 1'b0;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= (tof_reg || timeout) && ctrl_reg.irq_enable;
        end
    end

    wdt_delay #(
        .DELAY (wdt_pkg::RST_DELAY_CYC)
    ) u_delay (
        .i_core_clk (i_core_clk),
        .i_arst_n   (i_arst_n),
        .i_start    (timeout),
        .i_cancel   (restart),
        .o_pending  (pending),
        .o_expire   (expire)
    );

    // Reset pulse held one cycle; the device reset tree takes it from here
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_reg <= 1'b0;
        end else begin
            rst_reg <= expire && ctrl_reg.reset_enable;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rdata_reg <= '0;
        end else if (req.rd) begin
            rdata_reg <= '0;
            unique case (req.addr)
                wdt_pkg::CTRL_OFFS: begin
                    rdata_reg[wdt_pkg::CTRL_SEL_LSB +: 2] <=
                        ctrl_reg.interval_select;
                    rdata_reg[wdt_pkg::CTRL_IE_BIT]   <= ctrl_reg.irq_enable;
                    rdata_reg[wdt_pkg::CTRL_RSTE_BIT] <=
                        ctrl_reg.reset_enable;
                end
                wdt_pkg::STATUS_OFFS: begin
                    rdata_reg[wdt_pkg::STAT_TOF_BIT]  <= tof_reg;
                    rdata_reg[wdt_pkg::STAT_PEND_BIT] <= pending;
                end
                wdt_pkg::COUNT_OFFS: begin
                    rdata_reg <= count_reg[CW-1 -: wdt_pkg::DATA_W];
                end
                default: rdata_reg <= '0;
            endcase
        end else begin
            rdata_reg <= '0;
        end
    end

    assign o_rdata   = rdata_reg;
    assign o_irq     = irq_reg;
    assign o_sys_rst = rst_reg;

    // Cycles since the last timeout, kept for the delay checks only;
    // saturates so a long quiet spell cannot wrap back onto the delay
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            since_reg <= '1;
        end else if (timeout) begin
            since_reg <= '0;
        end else if (since_reg != '1) begin
            since_reg <= since_reg + 1'b1;
        end
    end

    // Interval exponents indexed by select code
    localparam int EXP_TAB [4] = '{wdt_pkg::EXP_SEL0, wdt_pkg::EXP_SEL1,
                                   wdt_pkg::EXP_SEL2, wdt_pkg::EXP_SEL3};

    for (genvar s = 0; s < 4; s++) begin : g_sel
        chk_sel_end: assert property (@(posedge i_core_clk)
            disable iff (!i_arst_n)
            (ctrl_reg.interval_select == 2'(s) && !restart
             && count_reg == CW'((1 << EXP_TAB[s]) - 1)) |-> timeout)
            else $error("interval end missed");

        chk_sel_early: assert property (@(posedge i_core_clk)
            disable iff (!i_arst_n)
            (ctrl_reg.interval_select == 2'(s) && timeout)
            |-> count_reg >= CW'((1 << EXP_TAB[s]) - 1))
            else $error("timeout before interval end");
    end

    chk_count_step: assert property (@(posedge i_core_clk)
        disable iff (!i_arst_n)
        (!restart && !timeout) |=> count_reg == CW'($past(count_reg) + 1'b1))
        else $error("counter did not advance");

    chk_wrap_zero: assert property (@(posedge i_core_clk)
        disable iff (!i_arst_n) timeout |=> count_reg == '0)
        else $error("counter not cleared at interval end");

    chk_ctrl_write: assert property (@(posedge i_core_clk)
        disable iff (!i_arst_n)
        wr_hit(req, wdt_pkg::CTRL_OFFS) |=> ctrl_reg.interval_select
            == $past(req.wdata[wdt_pkg::CTRL_SEL_LSB +: 2]))
        else $error("select not taken from write");

    chk_irq_drop: assert property (@(posedge i_core_clk)
        disable iff (!i_arst_n) !ctrl_reg.irq_enable |=> !o_irq)
        else $error("interrupt with enable clear");

    chk_irq_level: assert property (@(posedge i_core_clk)
        disable iff (!i_arst_n)
        (tof_reg && ctrl_reg.irq_enable) |=> o_irq)
        else $error("interrupt not held with flag set");

    chk_flag_clear: assert property (@(posedge i_core_clk)
        disable iff (!i_arst_n) (tof_clr && !timeout) |=> !tof_reg)
        else $error("timeout flag not cleared");

    chk_flag_quiet: assert property (@(posedge i_core_clk)
        disable iff (!i_arst_n) (!tof_reg && !timeout) |=> !tof_reg)
        else $error("timeout flag set without timeout");

    chk_flag_cause: assert property (@(posedge i_core_clk)
        disable iff (!i_arst_n) $rose(tof_reg) |-> $past(timeout))
        else $error("timeout flag rose without cause");

    chk_delay_start: assert property (@(posedge i_core_clk)
        disable iff (!i_arst_n) timeout |=> pending)
        else $error("reset delay not started");

    chk_delay_cancel: assert property (@(posedge i_core_clk)
        disable iff (!i_arst_n) restart |=> !pending)
        else $error("reset delay not cancelled");

    chk_delay_bound: assert property (@(posedge i_core_clk)
        disable iff (!i_arst_n)
        pending |-> since_reg < 10'(wdt_pkg::RST_DELAY_CYC))
        else $error("reset delay overran");

    chk_reset_exact: assert property (@(posedge i_core_clk)
        disable iff (!i_arst_n)
        o_sys_rst |-> since_reg == 10'(wdt_pkg::RST_DELAY_CYC))
        else $error("system reset not at delay end");

    chk_reset_gate: assert property (@(posedge i_core_clk)
        disable iff (!i_arst_n) o_sys_rst |-> $past(ctrl_reg.reset_enable))
        else $error("system reset without enable");

    chk_reset_pulse: assert property (@(posedge i_core_clk)
        disable iff (!i_arst_n) o_sys_rst |=> !o_sys_rst)
        else $error("system reset longer than one cycle");

    // Read data must fall back to zero outside the answer cycle
    chk_rdata_idle: assert property (@(posedge i_core_clk)
        disable iff (!i_arst_n) !req.rd |=> o_rdata == '0)
        else $error("read data outside answer cycle");

    chk_restart_clears: assert property (@(posedge i_core_clk)
        disable iff (!i_arst_n) restart |=> count_reg == '0)
        else $error("counter not cleared by restart");

    chk_interval_end: assert property (@(posedge i_core_clk)
        disable iff (!i_arst_n)
        (count_reg == CW'((1 << wdt_pkg::EXP_SEL0) - 1)
         && ctrl_reg.interval_select == 2'h0 && !restart) |-> timeout)
        else $error("shortest interval end missed");

    chk_interval_range: assert property (@(posedge i_core_clk)
        disable iff (!i_arst_n)
        count_reg <= CW'((1 << wdt_pkg::EXP_SEL3) - 1))
        else $error("counter beyond longest interval");

    chk_irq_gate: assert property (@(posedge i_core_clk)
        disable iff (!i_arst_n)
        o_irq |-> $past(ctrl_reg.irq_enable))
        else $error("interrupt without enable");

    chk_irq_raise: assert property (@(posedge i_core_clk)
        disable iff (!i_arst_n)
        (timeout && ctrl_reg.irq_enable) |=> o_irq)
        else $error("interrupt not raised on timeout");

    chk_flag_sticky: assert property (@(posedge i_core_clk)
        disable iff (!i_arst_n)
        (tof_reg && !tof_clr) |=> tof_reg)
        else $error("timeout flag dropped by itself");

    chk_flag_set: assert property (@(posedge i_core_clk)
        disable iff (!i_arst_n) timeout |=> tof_reg)
        else $error("timeout flag not set");

    chk_reset_delay: assert property (@(posedge i_core_clk)
        disable iff (!i_arst_n)
        (timeout && ctrl_reg.reset_enable) ##1
        (!restart && ctrl_reg.reset_enable) [*8] |-> !o_sys_rst)
        else $error("system reset too early");

    chk_reset_cause: assert property (@(posedge i_core_clk)
        disable iff (!i_arst_n)
        o_sys_rst |-> $past(expire) && $past(pending))
        else $error("system reset without expired delay");
endmodule

// ==== testbench/watchdog_timeout_reset_test.sv ====
// Self-checking bench for the watchdog core
`timescale 1ns/10ps
module watchdog_timeout_reset_test;
    logic                       i_core_clk = 1'b0;
    logic                       i_arst_n   = 1'b0;
    logic [wdt_pkg::ADDR_W-1:0] i_addr     = 4'h0;
    logic [wdt_pkg::DATA_W-1:0] i_wdata    = 16'h0000;
    logic                       i_wr       = 1'b0;
    logic                       i_rd       = 1'b0;
    logic [wdt_pkg::DATA_W-1:0] o_rdata;
    logic                       o_irq;
    logic                       o_sys_rst;
    logic [wdt_pkg::DATA_W-1:0] rd_val;
    int                         err_total   = 0;
    int                         comparisons = 0;
    int                         cycles      = 0;
    int                         n;

    wdt_core DUT (
        .i_core_clk(i_core_clk),
        .i_arst_n  (i_arst_n),
        .i_addr    (i_addr),
        .i_wdata   (i_wdata),
        .i_wr      (i_wr),
        .i_rd      (i_rd),
        .o_rdata   (o_rdata),
        .o_irq     (o_irq),
        .o_sys_rst (o_sys_rst)
    );

    always #20 i_core_clk = ~i_core_clk;

    // Ceiling covers three full minimum intervals plus margin
    always @(posedge i_core_clk) begin
        cycles++;
        if (cycles == 99900) begin
            err_total++;
            conclude();
        end
    end

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic check(input bit ok, input string msg);
        comparisons++;
        if (!ok) begin
            err_total++;
            $display("ERROR %0t %s", $time, msg);
        end
    endtask

    function automatic logic [15:0] ctrl(input logic [1:0] s, input logic ie,
                                         input logic rste);
        return {11'h000, 1'b1, rste, ie, s};
    endfunction

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge i_core_clk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a);
        @(posedge i_core_clk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        #1 rd_val = o_rdata;
    endtask

    task automatic t_reset();
        repeat (3) @(posedge i_core_clk);
        check(o_irq === 1'b0 && o_sys_rst === 1'b0, "outputs in reset");
        i_arst_n <= 1'b1;
        rd(wdt_pkg::CTRL_OFFS);
        check(rd_val === 16'h0000, "ctrl reset value");
        rd(4'hc);
        check(rd_val === 16'h0000, "unmapped read");
    endtask

    task automatic t_timeout();
        wr(wdt_pkg::CTRL_OFFS, ctrl(2'h0, 1'b1, 1'b1));
        n = 0;
        while (o_irq !== 1'b1 && n < 40000) begin
            @(posedge i_core_clk);
            #1 n++;
        end
        check(n >= 32767 && n <= 32769, "interval 00 length");
        n = 0;
        while (o_sys_rst !== 1'b1 && n < 600) begin
            @(posedge i_core_clk);
            #1 n++;
        end
        check(n == 512, "reset delay after timeout");
        @(posedge i_core_clk);
        #1 check(o_sys_rst === 1'b0, "reset pulse one cycle");
    endtask

    task automatic t_sticky();
        rd(wdt_pkg::STATUS_OFFS);
        check(rd_val[0] === 1'b1 && o_irq === 1'b1, "flag sticky");
        wr(wdt_pkg::STATUS_OFFS, 16'h0001);
        repeat (2) @(posedge i_core_clk);
        #1 check(o_irq === 1'b0, "irq drops on clear");
    endtask

    task automatic t_masked();
        wr(wdt_pkg::CTRL_OFFS, ctrl(2'h0, 1'b0, 1'b1));
        repeat (32772) @(posedge i_core_clk);
        rd(wdt_pkg::STATUS_OFFS);
        check(rd_val[1:0] === 2'h3 && o_irq === 1'b0, "masked timeout");
        wr(wdt_pkg::CTRL_OFFS, ctrl(2'h0, 1'b0, 1'b1));
        n = 0;
        repeat (600) begin
            @(posedge i_core_clk);
            #1 if (o_sys_rst === 1'b1) n++;
        end
        check(n == 0, "restart cancels reset");
        rd(wdt_pkg::STATUS_OFFS);
        check(rd_val[1] === 1'b0, "delay stopped");
        wr(wdt_pkg::STATUS_OFFS, 16'h0001);
    endtask

    // Longer select must not expire at the minimum interval
    task automatic t_long();
        wr(wdt_pkg::CTRL_OFFS, ctrl(2'h1, 1'b1, 1'b1));
        repeat (32800) @(posedge i_core_clk);
        rd(wdt_pkg::STATUS_OFFS);
        check(rd_val[0] === 1'b0 && o_irq === 1'b0, "select 01 early");
        rd(wdt_pkg::COUNT_OFFS);
        check(rd_val === 16'h0040, "counter runs past 2^15");
    endtask

    initial begin
        t_reset();
        t_timeout();
        t_sticky();
        t_masked();
        t_long();
        conclude();
    end
endmodule
